// ==== inc/fcm_regs.vh ====
`ifndef FCM_REGS_VH
`define FCM_REGS_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define FCM_IDX_PIR 16'h000c
`define FCM_IDX_PIE 16'h008c
`define FCM_IDX_OSC 16'h008f
`define FCM_IDX_TUNE 16'h0090
`define FCM_IDX_CFG 16'h2007
`define FCM_IDX_EXT 16'h0100
`define FCM_IDX_PWR 16'h0101

// ****************************************************************
// Field positions
// ****************************************************************
`define FCM_OSF_BIT 2
`define FCM_SCS_BIT 0
`define FCM_INTERNAL_FREQ_SELECT_LSB 4
`define FCM_INTERNAL_FREQ_SELECT_MSB 6
`define FCM_OSC_MODE_FIELD_MSB 2
`define FCM_TUNE_MSB 4
`define FCM_EXT_FAIL_SAFE_ENABLE_CFG_BIT 0
`define FCM_EXT_IESO_BIT 1
`define FCM_PWR_SLEEP_BIT 0
`define FCM_PWR_WAKE_BIT 1

// ****************************************************************
// Reset values and masks
// ****************************************************************
`define FCM_PIR_RST 8'h00
`define FCM_PIE_RST 8'h00
`define FCM_PIR_MASK 8'hef
`define FCM_INTERNAL_FREQ_SELECT_RST 3'h6
`define FCM_TUNE_RST 5'h00
`define FCM_CFG_RST 8'h00
`define FCM_EXT_RST 2'h0

// ****************************************************************
// Oscillator mode field encodings
// ****************************************************************
`define FCM_MODE_LP 3'h0
`define FCM_MODE_XT 3'h1
`define FCM_MODE_HS 3'h2
`define FCM_MODE_EC 3'h3
`define FCM_MODE_INT_IO 3'h4
`define FCM_MODE_INT_CLK 3'h5

// ****************************************************************
// Counts
// ****************************************************************
`define FCM_SAMPLE_DIV 64
`define FCM_OST_COUNT 1024
`define FCM_NUM_SYNC 5

`endif

// ==== hw/fcm_monitor.v ====
`timescale 1ns/1ps
`default_nettype none
`include "fcm_regs.vh"

// Operation
// - Monitor runs only when config enable set
// - Failure sets fail flag, interrupt if enabled
// - After failure system clock is internal oscillator
// - Entry clears timeout status, clears watchdog
// - Clock select and LF stable bit untouched
// - Sample clock is LF clock over 64
// - Latch cleared by sample rise, set primary fall
// - Sample fall with latch clear means failure
// - Monitor enable turns internal oscillator on
// - Primary at or below 488 Hz fails
// - Exit on reset, sleep, clock select change
// - Frequency writes keep fail-safe condition
// - Fail flag not clearable during fail-safe
// - EC and RC modes monitor right away; here only EC does, the internal (RC) modes are never monitored
// - Crystal modes run internal until timer expires
// - Detector idle during oscillator start-up
// - Frequency select decodes eight frequencies
// - Timeout status one when external clock runs
// - Bits two and one show oscillator stability
// - Clock select one picks internal oscillator
// - Timeout status resets to zero
// - Crystal modes wait 1024 oscillations
module fcm_monitor #(
   parameter SAMPLE_DIV = `FCM_SAMPLE_DIV,
   parameter DIV_W = 6,
   parameter OST_COUNT = `FCM_OST_COUNT,
   parameter OST_W = 11
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [17:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata_r,
   output reg pready_r,
   output reg pslverr_r,
   input wire prim_clk_in,
   input wire lf_osc_clk_in,
   input wire int_osc_clk_in,
   input wire hf_stable_in,
   input wire lf_stable_in,
   output reg sys_clk_out_r,
   output reg sys_clk_internal_r,
   output reg int_osc_enable_r,
   output reg [2:0] int_freq_sel_r,
   output reg osc_fail_irq_r,
   output reg watchdog_clear_r,
   output reg fail_safe_active_r
);

   localparam integer HALF_I = SAMPLE_DIV / 2 - 1;
   localparam integer OST_I = OST_COUNT - 1;
   localparam [DIV_W-1:0] HALF_M1 = HALF_I[DIV_W-1:0];
   localparam [OST_W-1:0] OST_M1 = OST_I[OST_W-1:0];

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   // Pclk must run well above four times the primary clock, or edges are lost
   // and the monitor declares a failure.
   wire [`FCM_NUM_SYNC-1:0] raw_in;
   wire [`FCM_NUM_SYNC-1:0] filt;
   reg [`FCM_NUM_SYNC-1:0] prev_r;

   assign raw_in = {lf_stable_in, hf_stable_in, int_osc_clk_in,
                    lf_osc_clk_in, prim_clk_in};

   genvar g;
   generate
      for (g = 0; g < `FCM_NUM_SYNC; g = g + 1) begin : g_sync
         reg s1_r;
         reg s2_r;
         reg s3_r;
         reg f_r;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
               s3_r <= 1'b0;
               f_r <= 1'b0;
            end else begin
               s1_r <= raw_in[g];
               s2_r <= s1_r;
               s3_r <= s2_r;
               if (s2_r == s3_r) begin
                  f_r <= s3_r;
               end
            end
         end
         assign filt[g] = f_r;
      end
   endgenerate

   wire prim_lvl = filt[0];
   wire int_lvl = filt[2];
   wire hf_stable = filt[3];
   wire lf_stable = filt[4];
   wire prim_fall = prev_r[0] & ~filt[0];
   wire lf_rise = ~prev_r[1] & filt[1];

   // ****************************************************************
   // Registers and decode
   // ****************************************************************
   reg [7:0] pir_r;
   reg [7:0] pie_r;
   reg scs_r;
   reg [4:0] tune_r;
   reg [7:0] cfg_r;
   reg [1:0] ext_r;
   reg sleeping_r;
   reg startup_done_r;
   reg [OST_W-1:0] ost_cnt_r;
   reg [DIV_W-1:0] div_cnt_r;
   reg sample_r;
   reg monitor_latch_r;
   reg armed_r;
   reg hold_r;

   wire [15:0] idx = paddr[17:2];
   wire hit_pir = (idx == `FCM_IDX_PIR);
   wire hit_pie = (idx == `FCM_IDX_PIE);
   wire hit_osc = (idx == `FCM_IDX_OSC);
   wire hit_tune = (idx == `FCM_IDX_TUNE);
   wire hit_cfg = (idx == `FCM_IDX_CFG);
   wire hit_ext = (idx == `FCM_IDX_EXT);
   wire hit_pwr = (idx == `FCM_IDX_PWR);
   wire hit_any = hit_pir | hit_pie | hit_osc | hit_tune | hit_cfg |
                  hit_ext | hit_pwr;

   wire setup = psel & ~penable;
   wire wr = psel & penable & pready_r & pwrite;
   wire wr_pir = wr & hit_pir;
   wire wr_osc = wr & hit_osc;
   wire wr_pwr = wr & hit_pwr;

   // ****************************************************************
   // Mode decode and clock source selection
   // ****************************************************************
   wire [2:0] osc_mode_field = cfg_r[`FCM_OSC_MODE_FIELD_MSB:0];
   wire ost_mode = (osc_mode_field == `FCM_MODE_LP) | (osc_mode_field == `FCM_MODE_XT) |
                   (osc_mode_field == `FCM_MODE_HS);
   wire ext_mode = (osc_mode_field != `FCM_MODE_INT_IO) &
                   (osc_mode_field != `FCM_MODE_INT_CLK);
   wire fcm_en = ext_r[`FCM_EXT_FAIL_SAFE_ENABLE_CFG_BIT];
   // Two-speed start-up comes on by itself with the monitor
   wire two_speed = ext_r[`FCM_EXT_IESO_BIT] | fcm_en;

   wire sleep_entry = wr_pwr & pwdata[`FCM_PWR_SLEEP_BIT] & ~sleeping_r;
   wire wake = wr_pwr & pwdata[`FCM_PWR_WAKE_BIT] & sleeping_r &
               ~pwdata[`FCM_PWR_SLEEP_BIT];
   wire scs_change = wr_osc & (pwdata[`FCM_SCS_BIT] != scs_r);

   wire use_internal = scs_r | fail_safe_active_r | ~ext_mode |
                       (~startup_done_r & ost_mode & two_speed);
   wire startup_timeout_status = startup_done_r & ~use_internal;

   // ****************************************************************
   // Start-up timer
   // ****************************************************************
   reg startup_nxt;
   reg [OST_W-1:0] ost_cnt_nxt;
   always @* begin
      startup_nxt = startup_done_r;
      ost_cnt_nxt = ost_cnt_r;
      if (sleeping_r | sleep_entry) begin
         // Sleep aborts start-up; status stays clear
         startup_nxt = 1'b0;
         ost_cnt_nxt = {OST_W{1'b0}};
      end else if (!startup_done_r) begin
         if (!ost_mode) begin
            startup_nxt = 1'b1;
         end else if (prim_fall) begin
            if (ost_cnt_r == OST_M1) begin
               startup_nxt = 1'b1;
               ost_cnt_nxt = {OST_W{1'b0}};
            end else begin
               ost_cnt_nxt = ost_cnt_r + 1'b1;
            end
         end
      end
   end

   // ****************************************************************
   // Sample clock, monitoring latch and failure detection
   // ****************************************************************
   wire div_wrap = lf_rise & (div_cnt_r == HALF_M1);
   wire sample_rise = div_wrap & ~sample_r;
   wire sample_fall = div_wrap & sample_r;
   wire det_active = fcm_en & ext_mode & startup_done_r &
                     ~sleeping_r & ~fail_safe_active_r;
   // A window opened before activation could hold a stale clear latch,
   // so detection waits for a whole window of its own, from a sample rise to the next sample fall.
   wire fault = sample_fall & armed_r & det_active &
                ~monitor_latch_r & ~prim_fall;

   reg latch_nxt;
   always @* begin
      latch_nxt = monitor_latch_r;
      if (prim_fall) begin
         latch_nxt = 1'b1;
      end else if (sample_rise) begin
         latch_nxt = 1'b0;
      end
   end

   reg fail_safe_nxt;
   always @* begin
      fail_safe_nxt = fail_safe_active_r;
      if (sleep_entry | scs_change) begin
         fail_safe_nxt = 1'b0;
      end else if (fault) begin
         fail_safe_nxt = 1'b1;
      end
   end

   reg [7:0] pir_nxt;
   always @* begin
      pir_nxt = pir_r;
      if (wr_pir) begin
         pir_nxt = pwdata[7:0] & `FCM_PIR_MASK;
         if (fail_safe_active_r) begin
            pir_nxt[`FCM_OSF_BIT] = pir_r[`FCM_OSF_BIT];
         end
      end
      if (fault) begin
         pir_nxt[`FCM_OSF_BIT] = 1'b1;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_r <= {`FCM_NUM_SYNC{1'b0}};
         div_cnt_r <= {DIV_W{1'b0}};
         sample_r <= 1'b0;
         monitor_latch_r <= 1'b0;
         armed_r <= 1'b0;
         fail_safe_active_r <= 1'b0;
         watchdog_clear_r <= 1'b0;
         osc_fail_irq_r <= 1'b0;
         startup_done_r <= 1'b0;
         ost_cnt_r <= {OST_W{1'b0}};
         int_osc_enable_r <= 1'b0;
      end else begin
         prev_r <= filt;
         if (lf_rise) begin
            if (div_wrap) begin
               div_cnt_r <= {DIV_W{1'b0}};
               sample_r <= ~sample_r;
            end else begin
               div_cnt_r <= div_cnt_r + 1'b1;
            end
         end
         monitor_latch_r <= latch_nxt;
         if (!det_active) begin
            armed_r <= 1'b0;
         end else if (sample_rise) begin
            armed_r <= 1'b1;
         end
         fail_safe_active_r <= fail_safe_nxt;
         watchdog_clear_r <= fault;
         osc_fail_irq_r <= pir_nxt[`FCM_OSF_BIT] &
                           pie_r[`FCM_OSF_BIT];
         startup_done_r <= startup_nxt;
         ost_cnt_r <= ost_cnt_nxt;
         int_osc_enable_r <= fcm_en | use_internal;
      end
   end

   // ****************************************************************
   // Glitch-free system clock switch
   // ****************************************************************
   wire cur_lvl = sys_clk_internal_r ? int_lvl : prim_lvl;
   wire new_lvl = sys_clk_internal_r ? prim_lvl : int_lvl;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_clk_out_r <= 1'b0;
         sys_clk_internal_r <= 1'b0;
         hold_r <= 1'b0;
      end else if (hold_r) begin
         sys_clk_out_r <= 1'b0;
         if (!new_lvl) begin
            sys_clk_internal_r <= ~sys_clk_internal_r;
            hold_r <= 1'b0;
         end
      end else if ((use_internal != sys_clk_internal_r) &&
                   (!cur_lvl || fail_safe_active_r)) begin
         // A dead primary may be stuck high; cutting it gives no runt
         hold_r <= 1'b1;
         sys_clk_out_r <= 1'b0;
      end else begin
         sys_clk_out_r <= cur_lvl;
      end
   end

   // ****************************************************************
   // Register file and APB slave
   // ****************************************************************
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h0000_0000;
      if (hit_pir) begin
         rd_mux[7:0] = pir_r;
      end else if (hit_pie) begin
         rd_mux[7:0] = pie_r;
      end else if (hit_osc) begin
         rd_mux[7:0] = {1'b0, int_freq_sel_r, startup_timeout_status,
                        hf_stable, lf_stable, scs_r};
      end else if (hit_tune) begin
         rd_mux[`FCM_TUNE_MSB:0] = tune_r;
      end else if (hit_cfg) begin
         rd_mux[7:0] = cfg_r;
      end else if (hit_ext) begin
         rd_mux[1:0] = ext_r;
      end else if (hit_pwr) begin
         rd_mux[2:0] = {startup_done_r, fail_safe_active_r, sleeping_r};
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         pir_r <= `FCM_PIR_RST;
         pie_r <= `FCM_PIE_RST;
         int_freq_sel_r <= `FCM_INTERNAL_FREQ_SELECT_RST;
         scs_r <= 1'b0;
         tune_r <= `FCM_TUNE_RST;
         cfg_r <= `FCM_CFG_RST;
         ext_r <= `FCM_EXT_RST;
         sleeping_r <= 1'b0;
      end else begin
         pready_r <= setup;
         pslverr_r <= setup & ~hit_any;
         if (setup && !pwrite) begin
            prdata_r <= rd_mux;
         end
         pir_r <= pir_nxt;
         if (wr & hit_pie) begin
            pie_r <= pwdata[7:0];
         end
         if (wr_osc) begin
            // Frequency writes never touch the fail-safe state
            int_freq_sel_r <= pwdata[`FCM_INTERNAL_FREQ_SELECT_MSB:`FCM_INTERNAL_FREQ_SELECT_LSB];
            scs_r <= pwdata[`FCM_SCS_BIT];
         end
         if (wr & hit_tune) begin
            tune_r <= pwdata[`FCM_TUNE_MSB:0];
         end
         if (wr & hit_cfg) begin
            cfg_r <= pwdata[7:0];
         end
         if (wr & hit_ext) begin
            ext_r <= pwdata[1:0];
         end
         if (sleep_entry) begin
            sleeping_r <= 1'b1;
         end else if (wake) begin
            sleeping_r <= 1'b0;
         end
      end
   end

endmodule // fcm_monitor
`default_nettype wire

// ==== tb/fcm_ext_osc.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// External clock source
// ****************************************************************
module fcm_ext_osc #(
   parameter HALF = 100,
   parameter PH = 7
) (
   input wire logic run,
   output logic clk
);
   // Odd start offset keeps edges off the bus clock edges
   initial begin
      clk = 1'b0;
      #(PH);
      forever begin
         #(HALF);
         // A dead source parks low, as a stalled crystal would
         clk = run ? ~clk : 1'b0;
      end
   end
endmodule // fcm_ext_osc
`default_nettype wire

// ==== tb/fcm_monitor_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checker
// ****************************************************************
module fcm_monitor_sva #(
   parameter SAMPLE_DIV = 64,
   parameter OST_COUNT = 1024
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire pready_r,
   input wire pslverr_r,
   input wire sys_clk_out_r,
   input wire sys_clk_internal_r,
   input wire int_osc_enable_r,
   input wire [2:0] int_freq_sel_r,
   input wire osc_fail_irq_r,
   input wire watchdog_clear_r,
   input wire fail_safe_active_r
);
   wire wr_acc = psel && penable && pwrite && pready_r;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ans; psel && !penable |=> pready_r; endproperty
   property p_rdy; pready_r |-> psel && penable ##1 !pready_r; endproperty
   property p_err; pslverr_r |-> pready_r; endproperty
   property p_wd_entry; $rose(fail_safe_active_r) |-> watchdog_clear_r;
   endproperty
   property p_wd_pulse; watchdog_clear_r |-> fail_safe_active_r
      ##1 !watchdog_clear_r; endproperty
   property p_int_en; fail_safe_active_r |-> int_osc_enable_r; endproperty
   property p_switch; $rose(fail_safe_active_r) |->
      ##[0:40] sys_clk_internal_r; endproperty
   property p_keep; fail_safe_active_r && sys_clk_internal_r |=>
      sys_clk_internal_r || !fail_safe_active_r; endproperty
   property p_glitch; $changed(sys_clk_internal_r) |-> !sys_clk_out_r;
   endproperty
   property p_freq; $changed(int_freq_sel_r) |-> $past(wr_acc); endproperty
   property p_exit; $fell(fail_safe_active_r) |->
      $past(wr_acc) || $past(wr_acc, 2); endproperty
   a_ans: assert property (p_ans) else $error("no answer after setup");
   a_rdy: assert property (p_rdy) else $error("ready misplaced");
   a_err: assert property (p_err) else $error("error without ready");
   a_wd_entry: assert property (p_wd_entry)
      else $error("watchdog not cleared on entry");
   a_wd_pulse: assert property (p_wd_pulse)
      else $error("watchdog clear pulse wrong");
   a_int_en: assert property (p_int_en)
      else $error("internal oscillator off");
   a_switch: assert property (p_switch)
      else $error("no switch to internal clock");
   a_keep: assert property (p_keep)
      else $error("left internal clock early");
   a_glitch: assert property (p_glitch)
      else $error("clock switched while high");
   a_freq: assert property (p_freq)
      else $error("frequency changed without write");
   a_exit: assert property (p_exit)
      else $error("fail safe left without cause");
   c_fail: cover property ($rose(fail_safe_active_r));
   c_exit: cover property ($fell(fail_safe_active_r));
   c_irq: cover property ($rose(osc_fail_irq_r));
   c_err: cover property (pslverr_r);
endmodule // fcm_monitor_sva
bind fcm_monitor fcm_monitor_sva #(.SAMPLE_DIV(SAMPLE_DIV),
   .OST_COUNT(OST_COUNT)) u_sva (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pready_r(pready_r),
   .pslverr_r(pslverr_r), .sys_clk_out_r(sys_clk_out_r),
   .sys_clk_internal_r(sys_clk_internal_r),
   .int_osc_enable_r(int_osc_enable_r), .int_freq_sel_r(int_freq_sel_r),
   .osc_fail_irq_r(osc_fail_irq_r), .watchdog_clear_r(watchdog_clear_r),
   .fail_safe_active_r(fail_safe_active_r));
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fcm_regs.vh"
// ****************************************************************
// Bench
// ****************************************************************
module testbench;
   logic pclk, presetn, psel, penable, pwrite, prim_run, osc_run, ev;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata_r, rdv;
   logic [1:0] stab;
   logic pready_r, pslverr_r, prim_clk, lf_clk, int_clk, sys_clk_out_r;
   logic sys_clk_internal_r, int_osc_enable_r, osc_fail_irq_r;
   logic watchdog_clear_r, fail_safe_active_r;
   logic [2:0] int_freq_sel_r;
   int errors, num_checks, i;
   int wd_seen = 0;
   // Default start offset keeps every source clear of the bus clock edges
   fcm_ext_osc u_prim (.run(prim_run), .clk(prim_clk));
   fcm_ext_osc #(.HALF(200)) u_lf (.run(osc_run), .clk(lf_clk));
   fcm_ext_osc #(.HALF(80)) u_int (.run(osc_run), .clk(int_clk));
   // Short counts keep the run brief; counter width stays at its default
   fcm_monitor #(.SAMPLE_DIV(4), .OST_COUNT(8)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
      .pready_r(pready_r), .pslverr_r(pslverr_r), .prim_clk_in(prim_clk),
      .lf_osc_clk_in(lf_clk), .int_osc_clk_in(int_clk),
      .hf_stable_in(stab[1]), .lf_stable_in(stab[0]),
      .sys_clk_out_r(sys_clk_out_r), .sys_clk_internal_r(sys_clk_internal_r),
      .int_osc_enable_r(int_osc_enable_r), .int_freq_sel_r(int_freq_sel_r),
      .osc_fail_irq_r(osc_fail_irq_r), .watchdog_clear_r(watchdog_clear_r),
      .fail_safe_active_r(fail_safe_active_r));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (watchdog_clear_r === 1'b1) wd_seen <= wd_seen + 1;
   end
   task automatic final_report();
      begin
         $display("checks %0d errors %0d", num_checks, errors);
         if (errors == 0 && num_checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      begin
         num_checks++;
         if (g !== e) begin
            errors++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   task automatic lv(input logic g, input logic e);
      chk({31'h0, g}, {31'h0, e});
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [15:0] ix,
                      input logic [7:0] d);
      int n;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= {ix, 2'b00};
         pwdata <= {24'h000000, d};
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while (pready_r !== 1'b1 && n < 16);
         if (n >= 16) begin
            lv(1'b0, 1'b1);
            final_report();
         end
         rdv = prdata_r;
         ev = pslverr_r;
         psel <= 1'b0;
         penable <= 1'b0;
         // Let this edge's register updates land before callers look
         #1;
      end
   endtask
   task automatic rd(input logic [15:0] ix, input logic [7:0] e);
      begin
         apb(1'b0, ix, 8'h00);
         chk(rdv, {24'h000000, e});
      end
   endtask
   task automatic wr(input logic [15:0] ix, input logic [7:0] d);
      apb(1'b1, ix, d);
   endtask
   // The selected source must reach the system clock output toggling
   task automatic clk_live();
      int hi;
      begin
         hi = 0;
         repeat (12) begin
            idle(1);
            hi += sys_clk_out_r;
         end
         lv(hi > 0 && hi < 12, 1'b1);
      end
   endtask
   task automatic slp_wake();
      begin
         wr(`FCM_IDX_PWR, 8'h01);
         wr(`FCM_IDX_PWR, 8'h02);
      end
   endtask
   task automatic wait_fs(input logic v);
      int n;
      begin
         for (n = 0; n < 500 && fail_safe_active_r !== v; n++) idle(1);
         lv(fail_safe_active_r, v);
         if (n == 500) final_report();
      end
   endtask
   task automatic rst();
      begin
         presetn <= 1'b0;
         idle(16);
         presetn <= 1'b1;
         idle(1);
      end
   endtask
   initial begin
      errors = 0;
      num_checks = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 18'h00000;
      pwdata = 32'h00000000;
      prim_run = 1'b0;
      osc_run = 1'b1;
      stab = 2'b11;
      rst();
      rd(`FCM_IDX_PIR, 8'h00);
      rd(`FCM_IDX_PIE, 8'h00);
      rd(`FCM_IDX_OSC, 8'h66);
      lv(int_freq_sel_r === 3'h6, 1'b1);
      apb(1'b0, 16'h0200, 8'h00);
      lv(ev, 1'b1);
      chk(rdv, 32'h00000000);
      idle(1);
      stab <= 2'b10;
      idle(10);
      rd(`FCM_IDX_OSC, 8'h64);
      idle(1);
      stab <= 2'b11;
      $display("test 1 done");
      wr(`FCM_IDX_CFG, 8'h03);
      wr(`FCM_IDX_PIE, 8'h04);
      wr(`FCM_IDX_EXT, 8'h01);
      prim_run <= 1'b1;
      slp_wake();
      idle(100);
      lv(fail_safe_active_r, 1'b0);
      rd(`FCM_IDX_OSC, 8'h6e);
      lv(int_osc_enable_r, 1'b1);
      prim_run <= 1'b0;
      wait_fs(1'b1);
      idle(20);
      rd(`FCM_IDX_PIR, 8'h04);
      lv(osc_fail_irq_r, 1'b1);
      rd(`FCM_IDX_OSC, 8'h66);
      lv(wd_seen == 1, 1'b1);
      lv(sys_clk_internal_r, 1'b1);
      clk_live();
      $display("test 2 done");
      wr(`FCM_IDX_PIR, 8'h00);
      rd(`FCM_IDX_PIR, 8'h04);
      wr(`FCM_IDX_PIE, 8'h00);
      idle(2);
      lv(osc_fail_irq_r, 1'b0);
      wr(`FCM_IDX_PIE, 8'h04);
      for (i = 0; i < 8; i++) begin
         wr(`FCM_IDX_OSC, {1'b0, i[2:0], 4'h0});
         lv(int_freq_sel_r === i[2:0], 1'b1);
      end
      lv(fail_safe_active_r, 1'b1);
      wr(`FCM_IDX_OSC, 8'h60);
      $display("test 3 done");
      prim_run <= 1'b1;
      wr(`FCM_IDX_OSC, 8'h61);
      wait_fs(1'b0);
      rd(`FCM_IDX_OSC, 8'h67);
      wr(`FCM_IDX_PIR, 8'h00);
      rd(`FCM_IDX_PIR, 8'h00);
      wr(`FCM_IDX_OSC, 8'h60);
      idle(100);
      lv(sys_clk_internal_r, 1'b0);
      clk_live();
      lv(osc_fail_irq_r, 1'b0);
      $display("test 4 done");
      prim_run <= 1'b0;
      wait_fs(1'b1);
      wr(`FCM_IDX_PWR, 8'h01);
      wait_fs(1'b0);
      prim_run <= 1'b1;
      wr(`FCM_IDX_PWR, 8'h02);
      idle(50);
      prim_run <= 1'b0;
      wait_fs(1'b1);
      rst();
      lv(fail_safe_active_r, 1'b0);
      rd(`FCM_IDX_PIR, 8'h00);
      $display("test 5 done");
      wr(`FCM_IDX_CFG, 8'h03);
      prim_run <= 1'b1;
      slp_wake();
      idle(50);
      prim_run <= 1'b0;
      idle(400);
      lv(fail_safe_active_r, 1'b0);
      $display("test 6 done");
      wr(`FCM_IDX_CFG, 8'h00);
      wr(`FCM_IDX_EXT, 8'h01);
      slp_wake();
      idle(400);
      lv(fail_safe_active_r, 1'b0);
      rd(`FCM_IDX_OSC, 8'h66);
      lv(sys_clk_internal_r, 1'b1);
      prim_run <= 1'b1;
      idle(100);
      rd(`FCM_IDX_OSC, 8'h6e);
      prim_run <= 1'b0;
      wait_fs(1'b1);
      $display("test 7 done");
      final_report();
   end
endmodule // testbench
`default_nettype wire
